/* core/ets_map.vh */
`ifndef ETS_MAP_VH
`define ETS_MAP_VH
// Oscillator and tick
`define ETS_CLK_HZ          40000000
`define ETS_TICK_HZ         1000
`define ETS_TICK_DIV        (`ETS_CLK_HZ / `ETS_TICK_HZ)
// Epoch spacing in ticks at one fix per second
`define ETS_FIX_TICKS       16'h03e8
`define ETS_FIX_TICKS_SHORT 16'h03e7
`define ETS_FIX_TICKS_LONG  16'h03e9
// Drift threshold in microseconds before one tick is stretched or shrunk
`define ETS_DRIFT_STEP_US   32'sh000001f4
`define ETS_US_PER_TICK     32'sh000003e8
// Time of week wrap, milliseconds in one week
`define ETS_WEEK_MS         32'h240c8400
// Default leap second offset used without broadcast or aided parameters
`define ETS_DEF_LEAP_S      8'h12
`define ETS_MS_PER_S        32'h000003e8
// Source select codes
`define ETS_SRC_GPS         2'h0
`define ETS_SRC_GLO         2'h1
`endif

/* core/ets_tick_div.v */
`timescale 1ns/1ps
`include "ets_map.vh"
module ets_tick_div #(
	parameter DIV = `ETS_TICK_DIV
) (
	input  wire clk,
	input  wire sys_rst,
	output reg  tick
);
	reg [31:0] count;
	// Free running divider, tick marks each 1 kHz edge
	always @(posedge clk) begin
		if (sys_rst) begin
			count <= 32'h00000000;
			tick  <= 1'b0;
		end else if (count == DIV - 1) begin
			count <= 32'h00000000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h00000001;
			tick  <= 1'b0;
		end
	end
endmodule // ets_tick_div

/* core/ets_utc_conv.v */
`timescale 1ns/1ps
`include "ets_map.vh"
module ets_utc_conv (
	input  wire [31:0] sys_tow_ms,
	input  wire [15:0] sys_week,
	input  wire [1:0]  time_source,
	input  wire        leap_known,
	input  wire [7:0]  leap_s,
	input  wire [31:0] glo_gps_off_ms,
	input  wire        glo_off_known,
	output wire [31:0] gps_tow_ms,
	output wire [15:0] gps_week,
	output wire [31:0] utc_tow_ms,
	output wire [15:0] utc_week,
	output wire        exact
);
	wire        is_glo;
	wire [7:0]  leap_use;
	wire [31:0] leap_ms;
	wire [32:0] gps_sum;
	wire        gps_wrap;
	wire        utc_borrow;
	assign is_glo = (time_source == `ETS_SRC_GLO);
	// Defaults keep times plausible, flagged below as not exact: GPS source without leap seconds, GLONASS source without its offset
	assign leap_use = leap_known ? leap_s : `ETS_DEF_LEAP_S;
	assign leap_ms  = {24'h000000, leap_use} * `ETS_MS_PER_S;
	// GLONASS needs its offset to reach GPS; GPS base needs none
	assign gps_sum  = {1'b0, sys_tow_ms} + {1'b0, (is_glo ? glo_gps_off_ms : 32'h00000000)};
	assign gps_wrap = (gps_sum >= {1'b0, `ETS_WEEK_MS});
	assign gps_tow_ms = gps_wrap ? gps_sum[31:0] - `ETS_WEEK_MS : gps_sum[31:0];
	assign gps_week   = gps_wrap ? sys_week + 16'h0001 : sys_week;
	assign utc_borrow = (gps_tow_ms < leap_ms);
	assign utc_tow_ms = utc_borrow ? gps_tow_ms + `ETS_WEEK_MS - leap_ms : gps_tow_ms - leap_ms;
	assign utc_week   = utc_borrow ? gps_week - 16'h0001 : gps_week;
	assign exact = is_glo ? glo_off_known : leap_known;
endmodule // ets_utc_conv

/* core/ets_scheduler.v */
`timescale 1ns/1ps
`include "ets_map.vh"
//////////////////////////////////////////////////////////////////////////////
module ets_scheduler #(
	parameter TICK_DIV = `ETS_TICK_DIV
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        time_fix_valid,
	input  wire [31:0] time_fix_tow_ms,
	input  wire [15:0] time_fix_week,
	input  wire        date_fix_valid,
	input  wire [1:0]  time_source,
	input  wire        solution_valid,
	input  wire [31:0] solution_tow_ms,
	input  wire [15:0] solution_week,
	input  wire signed [31:0] solution_frac_us,
	input  wire        utc_bcast_valid,
	input  wire [7:0]  utc_bcast_leap_s,
	input  wire        utc_aid_valid,
	input  wire [7:0]  utc_aid_leap_s,
	input  wire [31:0] glo_gps_off_ms,
	input  wire        glo_off_valid,
	input  wire        confirm_date_in,
	input  wire        confirm_time_in,
	input  wire        confirm_available_in,
	output wire        ref_tick,
	output wire        meas_sample,
	output reg         epoch_strobe,
	output reg  [31:0] local_tow_ms,
	output reg  [15:0] local_week,
	output reg         local_time_mapped,
	output reg  signed [31:0] clock_bias_ms,
	output reg  signed [31:0] clock_drift_ms,
	output reg  [15:0] epoch_ticks,
	output reg  [31:0] epoch_time_of_week,
	output reg  [15:0] report_gps_week,
	output reg  [31:0] report_utc_tow_ms,
	output reg  [15:0] report_utc_week,
	output reg         report_strobe,
	output reg         date_known_flag,
	output reg         time_known_flag,
	output reg         date_confirmed_flag,
	output reg         time_confirmed_flag,
	output reg         confirmation_available_flag,
	output reg         utc_second_resolved_flag
);
	localparam ST_IDLE = 2'b01;
	localparam ST_WAIT = 2'b10;
	reg  [1:0]  state;
	reg  [15:0] tick_count;
	reg  signed [31:0] drift_acc_us;
	reg  signed [31:0] prev_bias_ms;
	reg         leap_known;
	reg  [7:0]  leap_s;
	reg  [31:0] sol_tow;
	reg  [15:0] sol_week;
	reg         sol_pending;
	reg  [15:0] next_ticks;
	reg  signed [31:0] next_drift;
	reg  signed [31:0] drift_sum;
	wire        tick;
	wire [31:0] gps_tow;
	wire [15:0] gps_week;
	wire [31:0] utc_tow;
	wire [15:0] utc_week;
	wire        conv_exact;
	wire [31:0] next_tow_raw;

	//////////////////////////////////////////////////////////////////////////
	ets_tick_div #(
		.DIV (TICK_DIV)
	) u_div (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);
	assign ref_tick    = tick;
	assign meas_sample = tick;

	ets_utc_conv u_conv (
		.sys_tow_ms     (sol_tow),
		.sys_week       (sol_week),
		.time_source    (time_source),
		.leap_known     (leap_known),
		.leap_s         (leap_s),
		.glo_gps_off_ms (glo_gps_off_ms),
		.glo_off_known  (glo_off_valid),
		.gps_tow_ms     (gps_tow),
		.gps_week       (gps_week),
		.utc_tow_ms     (utc_tow),
		.utc_week       (utc_week),
		.exact          (conv_exact)
	);

	//////////////////////////////////////////////////////////////////////////
	// Local time: week plus time of week in ms
	assign next_tow_raw = local_tow_ms + 32'h00000001;
	always @(posedge clk) begin
		if (sys_rst) begin
			local_tow_ms      <= 32'h00000000;
			local_week        <= 16'h0000;
			local_time_mapped <= 1'b0;
		end else if (time_fix_valid) begin
			// Discontinuous jump; later ticks count on from here
			local_tow_ms      <= time_fix_tow_ms;
			local_week        <= time_fix_week;
			local_time_mapped <= 1'b1;
		end else if (tick) begin
			if (local_time_mapped && next_tow_raw == `ETS_WEEK_MS) begin
				local_tow_ms <= 32'h00000000;
				local_week   <= local_week + 16'h0001;
			end else begin
				local_tow_ms <= next_tow_raw;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Leap second source: aiding overrides broadcast in the same cycle, otherwise last one wins
	always @(posedge clk) begin
		if (sys_rst) begin
			leap_known <= 1'b0;
			leap_s     <= `ETS_DEF_LEAP_S;
		end else if (utc_aid_valid) begin
			leap_known <= 1'b1;
			leap_s     <= utc_aid_leap_s;
		end else if (utc_bcast_valid) begin
			leap_known <= 1'b1;
			leap_s     <= utc_bcast_leap_s;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Epoch spacing: drift accumulates until a tick's worth must be cancelled
	always @* begin
		drift_sum  = solution_valid ? drift_acc_us + solution_frac_us : drift_acc_us;
		next_drift = drift_sum;
		next_ticks = `ETS_FIX_TICKS;
		if (next_drift >= `ETS_DRIFT_STEP_US) begin
			next_ticks = `ETS_FIX_TICKS_SHORT;
			next_drift = next_drift - `ETS_US_PER_TICK;
		end else if (next_drift <= -`ETS_DRIFT_STEP_US) begin
			next_ticks = `ETS_FIX_TICKS_LONG;
			next_drift = next_drift + `ETS_US_PER_TICK;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state        <= ST_IDLE;
			tick_count   <= 16'h0000;
			epoch_ticks  <= `ETS_FIX_TICKS;
			drift_acc_us <= 32'sh00000000;
			epoch_strobe <= 1'b0;
		end else begin
			epoch_strobe <= 1'b0;
			// Residue kept between epochs so no solution's drift is lost
			if (solution_valid) begin
				drift_acc_us <= drift_sum;
			end
			case (state)
			ST_IDLE: begin
				// First epoch on the first tick after reset
				if (tick) begin
					epoch_strobe <= 1'b1;
					tick_count   <= 16'h0001;
					state        <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					if (tick_count == epoch_ticks) begin
						// Tick nearest to the desired solution time
						epoch_strobe <= 1'b1;
						tick_count   <= 16'h0001;
						epoch_ticks  <= next_ticks;
						drift_acc_us <= next_drift;
					end else begin
						tick_count <= tick_count + 16'h0001;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Bias and drift, sampled per solution
	always @(posedge clk) begin
		if (sys_rst) begin
			clock_bias_ms  <= 32'sh00000000;
			clock_drift_ms <= 32'sh00000000;
			prev_bias_ms   <= 32'sh00000000;
			sol_tow        <= 32'h00000000;
			sol_week       <= 16'h0000;
			sol_pending    <= 1'b0;
		end else begin
			sol_pending <= solution_valid;
			if (solution_valid) begin
				clock_bias_ms  <= $signed(solution_tow_ms - local_tow_ms);
				clock_drift_ms <= $signed(solution_tow_ms - local_tow_ms) - prev_bias_ms;
				prev_bias_ms   <= $signed(solution_tow_ms - local_tow_ms);
				sol_tow        <= solution_tow_ms;
				sol_week       <= solution_week;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Report: all fields updated together so one solution has one stamp
	always @(posedge clk) begin
		if (sys_rst) begin
			epoch_time_of_week          <= 32'h00000000;
			report_gps_week             <= 16'h0000;
			report_utc_tow_ms           <= 32'h00000000;
			report_utc_week             <= 16'h0000;
			report_strobe               <= 1'b0;
			date_known_flag             <= 1'b0;
			time_known_flag             <= 1'b0;
			date_confirmed_flag         <= 1'b0;
			time_confirmed_flag         <= 1'b0;
			confirmation_available_flag <= 1'b0;
			utc_second_resolved_flag    <= 1'b0;
		end else begin
			report_strobe <= sol_pending;
			if (sol_pending) begin
				epoch_time_of_week <= gps_tow;
				report_gps_week    <= gps_week;
				report_utc_tow_ms  <= utc_tow;
				report_utc_week    <= utc_week;
				// Defaulted conversions still report, but not as valid
				time_known_flag <= local_time_mapped & conv_exact;
				date_known_flag <= date_fix_valid & conv_exact;
				confirmation_available_flag <= confirm_available_in;
				// Held low while no confirmation source exists
				date_confirmed_flag <= confirm_available_in & confirm_date_in;
				time_confirmed_flag <= confirm_available_in & confirm_time_in;
				utc_second_resolved_flag <= (time_source == `ETS_SRC_GLO) | leap_known;
			end
		end
	end
endmodule // ets_scheduler

/* tb/ets_scheduler_asserts.sv */
`timescale 1ns/1ps
module ets_sched_asserts #(
	parameter TICK_DIV = 8
) (
	input wire        clk,
	input wire        sys_rst,
	input wire        time_fix_valid,
	input wire [31:0] time_fix_tow_ms,
	input wire        solution_valid,
	input wire        ref_tick,
	input wire        meas_sample,
	input wire        epoch_strobe,
	input wire [31:0] local_tow_ms,
	input wire        local_time_mapped,
	input wire [15:0] epoch_ticks,
	input wire        report_strobe,
	input wire        date_confirmed_flag,
	input wire        time_confirmed_flag,
	input wire        confirmation_available_flag
);
	localparam int TICK_GAP = TICK_DIV - 1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Report lands two cycles after the request
	sequence s_report_late;
		##2 report_strobe;
	endsequence
	a_tick_period: assert property (ref_tick |=> !ref_tick ##TICK_GAP ref_tick)
		else $error("tick period wrong");
	a_meas_aligned: assert property (meas_sample == ref_tick)
		else $error("sampling off the tick");
	a_epoch_on_tick: assert property (epoch_strobe |-> $past(ref_tick))
		else $error("epoch strobe not after tick");
	a_epoch_pulse: assert property (epoch_strobe |=> !epoch_strobe)
		else $error("epoch strobe too long");
	a_report_lat: assert property (solution_valid |-> s_report_late)
		else $error("report strobe late");
	a_spacing_legal: assert property (epoch_ticks inside {16'h03e7, 16'h03e8, 16'h03e9})
		else $error("epoch spacing illegal");
	a_fix_load: assert property (time_fix_valid |=>
		local_tow_ms == $past(time_fix_tow_ms) && local_time_mapped)
		else $error("local time not stepped");
	a_confirm_gate: assert property (!confirmation_available_flag |->
		!date_confirmed_flag && !time_confirmed_flag)
		else $error("confirmed flag without availability");
endmodule // ets_sched_asserts

bind ets_scheduler ets_sched_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.*);

/* tb/ets_host_model.sv */
`timescale 1ns/1ps
// Host side: latches each solution report as a message reader would
module ets_host_model (
	input  wire        clk,
	input  wire        report_strobe,
	input  wire [31:0] epoch_time_of_week,
	input  wire        date_confirmed_flag,
	input  wire        time_confirmed_flag,
	input  wire        confirmation_available_flag,
	output reg  [31:0] host_tow,
	output reg  [1:0]  host_conf
);
	initial host_tow = 32'h0;
	initial host_conf = 2'h0;
	always @(posedge clk) begin
		if (report_strobe) begin
			host_tow <= epoch_time_of_week;
			// Confirmations ignored unless the device says they exist
			host_conf <= confirmation_available_flag ?
				{date_confirmed_flag, time_confirmed_flag} : 2'h0;
		end
	end
endmodule // ets_host_model

/* tb/tb_ets_scheduler.sv */
`timescale 1ns/1ps
module tb_ets_scheduler;
	reg clk = 0, sys_rst = 1, time_fix_valid = 0, date_fix_valid = 0, solution_valid = 0;
	reg utc_bcast_valid = 0, utc_aid_valid = 0, glo_off_valid = 0;
	reg confirm_date_in = 0, confirm_time_in = 0, confirm_available_in = 0;
	reg [1:0] time_source = 2'h0;
	reg [31:0] time_fix_tow_ms = 0, solution_tow_ms = 0, glo_gps_off_ms = 0;
	reg [15:0] time_fix_week = 0, solution_week = 0;
	reg signed [31:0] solution_frac_us = 0;
	reg [7:0] utc_bcast_leap_s = 8'h12, utc_aid_leap_s = 8'h11;
	wire ref_tick, meas_sample, epoch_strobe, local_time_mapped, report_strobe;
	wire date_known_flag, time_known_flag, date_confirmed_flag, time_confirmed_flag;
	wire confirmation_available_flag, utc_second_resolved_flag;
	wire [31:0] local_tow_ms, epoch_time_of_week, report_utc_tow_ms, host_tow;
	wire signed [31:0] clock_bias_ms, clock_drift_ms;
	wire [15:0] local_week, epoch_ticks, report_gps_week, report_utc_week;
	wire [1:0] host_conf;
	integer err_count = 0, checked = 0, n;
	reg [31:0] a;
	localparam [31:0] T = 32'h000f4240;
	ets_scheduler #(.TICK_DIV(8)) dut (.*);
	ets_host_model host (.*);
	always #12.5 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("errors=%0d checks=%0d", err_count, checked);
			if (err_count == 0 && checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Bounded wait, counted in cycles, so a stuck strobe cannot hang
	task wait_ep;
		begin
			n = 0;
			while (epoch_strobe !== 1'b1 && n < 9000) begin
				@(negedge clk);
				n = n + 1;
			end
		end
	endtask
	task sol(input [31:0] tow, input signed [31:0] frac);
		begin
			solution_tow_ms = tow;
			solution_week = 16'h07d0;
			solution_frac_us = frac;
			solution_valid = 1;
			@(negedge clk) solution_valid = 0;
			@(negedge clk);
			chk(report_strobe, 1);
			chk(epoch_time_of_week, tow);
			chk(report_gps_week, 16'h07d0);
			@(negedge clk);
			chk(host_tow, tow);
		end
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 0;
		chk(epoch_ticks, 16'h03e8);
		chk(time_known_flag, 0);
		a = local_tow_ms;
		repeat (40) @(negedge clk);
		chk(local_tow_ms, a + 32'h4);
		wait_ep;
		@(negedge clk);
		wait_ep;
		chk(n, 32'h1f3f);
		time_fix_tow_ms = 32'h00010000;
		time_fix_week = 16'h07d0;
		time_fix_valid = 1;
		@(negedge clk) time_fix_valid = 0;
		chk(local_tow_ms, 32'h00010000);
		chk(local_week, 16'h07d0);
		sol(T, 0);
		chk(report_utc_tow_ms, T - 32'h00004650);
		chk(report_utc_week, 16'h07d0);
		chk(clock_bias_ms, T - 32'h00010000);
		chk(clock_drift_ms, T - 32'h00010000);
		chk(utc_second_resolved_flag, 0);
		chk(date_known_flag, 0);
		time_source = 2'h1;
		glo_off_valid = 1;
		date_fix_valid = 1;
		confirm_date_in = 1;
		confirm_time_in = 1;
		sol(T, 0);
		chk(utc_second_resolved_flag, 1);
		chk(date_known_flag, 1);
		chk(host_conf, 2'h0);
		time_source = 2'h0;
		confirm_available_in = 1;
		utc_bcast_valid = 1;
		@(negedge clk) utc_bcast_valid = 0;
		sol(T, 0);
		chk(utc_second_resolved_flag, 1);
		chk(time_known_flag, 1);
		chk(host_conf, 2'h3);
		utc_aid_valid = 1;
		@(negedge clk) utc_aid_valid = 0;
		sol(T, 32'sd500);
		chk(report_utc_tow_ms, T - 32'h00004268);
		for (n = 0; epoch_ticks !== 16'h03e7 && n < 9000; n = n + 1) @(negedge clk);
		chk(epoch_ticks, 16'h03e7);
		sol(T, -32'sd1000);
		for (n = 0; epoch_ticks !== 16'h03e9 && n < 9000; n = n + 1) @(negedge clk);
		chk(epoch_ticks, 16'h03e9);
		finish_test;
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_count = err_count + 1;
		finish_test;
	end
endmodule // tb_ets_scheduler
